// ==== hdl/rpw_alarm_window.sv ====
/*
 * Alarm compare values, alarm match and power-control window sequencer,
 * reached over AXI4-Lite.
 * Assumes the running clock digits arrive as BCD on time_now and that
 * pwc_tick is a one-cycle pulse per power-control clock period.
 */
`timescale 1ns/1ps
module rpw_alarm_window
    import rpw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire rpw_time_t time_now,
    input wire logic pwc_tick,
    output logic alarm_event,
    output logic power_control_out,
    output logic sample_window_open
);
    logic [15:0] alarm_wdhr;
    logic [15:0] alarm_minsec;
    logic [15:0] window_timer;
    logic [15:0] ctrl;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic wr_ok;
    logic [15:0] next_ctrl;
    logic [7:0] stab_cnt;
    logic [7:0] samp_cnt;
    rpw_state_t state;
    rpw_state_t next_state;
    logic alarm_match;
    logic pwc_active;
    logic seq_on;

    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0])
            r[7:0] = data[7:0];
        if (strb[1])
            r[15:8] = data[15:8];
        return r;
    endfunction : merge

    function automatic logic known(input logic [7:0] a);
        return a == ADDR_ALARM_WDHR || a == ADDR_ALARM_MINSEC ||
            a == ADDR_WINDOW || a == ADDR_CTRL || a == ADDR_STATUS;
    endfunction : known

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            aw_held <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
            aw_held <= 1'b1;
        else if (do_write)
            aw_held <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            aw_addr <= 8'h00;
        else if (s_axi_awvalid && s_axi_awready)
            aw_addr <= s_axi_awaddr;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // RULE4 write enable gate
    assign wr_ok = do_write && ctrl[CTRL_WREN];

    // RULE7 unimplemented bits masked
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alarm_wdhr <= RESET_VAL;
            alarm_minsec <= RESET_VAL;
            window_timer <= RESET_VAL;
        end
        else if (wr_ok)
        begin
            // RULE1 RULE2 RULE3 weekday/hour layout
            if (aw_addr == ADDR_ALARM_WDHR)
                alarm_wdhr <= merge(alarm_wdhr, w_data, w_strb) & WDHR_MASK;
            // RULE5 RULE6 minute/second layout
            if (aw_addr == ADDR_ALARM_MINSEC)
                alarm_minsec <= merge(alarm_minsec, w_data, w_strb)
                    & MINSEC_MASK;
            if (aw_addr == ADDR_WINDOW)
                window_timer <= merge(window_timer, w_data, w_strb);
        end
    end

    // RULE16 hardware clear wins over software set
    always_comb
    begin
        next_ctrl = ctrl;
        if (do_write && aw_addr == ADDR_CTRL)
            next_ctrl = merge(ctrl, w_data, w_strb) & CTRL_MASK;
        if (alarm_event)
            next_ctrl[CTRL_ALARM_EN] = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl <= RESET_VAL;
        else
            ctrl <= next_ctrl;
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                ADDR_ALARM_WDHR: s_axi_rdata <= {16'h0000, alarm_wdhr};
                ADDR_ALARM_MINSEC: s_axi_rdata <= {16'h0000, alarm_minsec};
                ADDR_WINDOW: s_axi_rdata <= {16'h0000, window_timer};
                ADDR_CTRL: s_axi_rdata <= {16'h0000, ctrl};
                ADDR_STATUS: s_axi_rdata <= {8'h00, samp_cnt, stab_cnt,
                    5'h00, state};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // RULE17 mask picks compared digits
    always_comb
    begin
        logic sec1;
        logic sec10;
        logic min1;
        logic min10;
        logic hr;
        logic wd;
        sec1 = time_now.sec_ones[3:0] == alarm_minsec[ALARM_SECOND_ONES_LSB +: 4];
        sec10 = time_now.sec_tens[2:0] == alarm_minsec[ALARM_SECOND_TENS_LSB +: 3];
        min1 = time_now.min_ones[3:0] == alarm_minsec[ALARM_MINUTE_ONES_LSB +: 4];
        min10 = time_now.min_tens[2:0] == alarm_minsec[ALARM_MINUTE_TENS_LSB +: 3];
        hr = time_now.hr_ones[3:0] == alarm_wdhr[ALARM_HOUR_ONES_LSB +: 4] &&
            time_now.hr_tens[1:0] == alarm_wdhr[ALARM_HOUR_TENS_LSB +: 2];
        wd = time_now.alarm_weekday_digit[2:0] == alarm_wdhr[ALARM_WEEKDAY_DIGIT_LSB +: 3];
        unique case (ctrl[CTRL_MASK_LSB +: 4])
            4'h0, 4'h1: alarm_match = 1'b1;
            4'h2: alarm_match = sec1;
            4'h3: alarm_match = sec1 && sec10;
            4'h4: alarm_match = sec1 && sec10 && min1;
            4'h5: alarm_match = sec1 && sec10 && min1 && min10;
            4'h6: alarm_match = sec1 && sec10 && min1 && min10 && hr;
            4'h7: alarm_match = sec1 && sec10 && min1 && min10 && hr && wd;
            default: alarm_match = 1'b0;
        endcase
    end

    // fires only on a pwc_tick; the alarm enable clear on alarm keeps a held match from retriggering
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            alarm_event <= 1'b0;
        else
            alarm_event <= pwc_tick && alarm_match && ctrl[CTRL_ALARM_EN]
                && !alarm_event;
    end

    // RULE14 module, enable and pin select
    assign seq_on = ctrl[CTRL_MODULE_EN] && ctrl[CTRL_PWC_EN] &&
        ctrl[CTRL_OUT_SEL];

    always_comb
    begin
        next_state = state;
        unique case (state)
            PW_IDLE:
                if (alarm_event && seq_on)
                begin
                    // RULE9 RULE13 zero stability skips phase
                    if (window_timer[STAB_LSB +: 8] != 8'h00)
                        next_state = PW_STAB;
                    else if (window_timer[SAMP_LSB +: 8] != 8'h00)
                        next_state = PW_SAMP;
                end
            PW_STAB:
                // RULE13 sample follows stability expiry
                if (pwc_tick && stab_cnt == 8'h01)
                    // RULE12 zero sample setting skips
                    next_state = (window_timer[SAMP_LSB +: 8] != 8'h00) ?
                        PW_SAMP : PW_IDLE;
            PW_SAMP:
                if (pwc_tick && samp_cnt == 8'h01)
                    next_state = PW_IDLE;
            default: next_state = PW_IDLE;
        endcase
        if (!seq_on)
            next_state = PW_IDLE;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= PW_IDLE;
        else
            state <= next_state;
    end

    // RULE18 load at alarm, count per period
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stab_cnt <= 8'h00;
            samp_cnt <= 8'h00;
        end
        else if (state == PW_IDLE && alarm_event)
        begin
            // RULE8 RULE11 N periods each phase
            stab_cnt <= window_timer[STAB_LSB +: 8];
            samp_cnt <= window_timer[SAMP_LSB +: 8];
        end
        else if (pwc_tick)
        begin
            if (state == PW_STAB && stab_cnt != 8'h00)
                stab_cnt <= stab_cnt - 8'h01;
            if (state == PW_SAMP && samp_cnt != 8'h00)
                samp_cnt <= samp_cnt - 8'h01;
        end
    end

    // RULE19 active from alarm until sample closes
    // RULE10 all ones holds window open regardless
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwc_active <= 1'b0;
            sample_window_open <= 1'b0;
        end
        else
        begin
            pwc_active <= next_state != PW_IDLE ||
                window_timer[SAMP_LSB +: 8] == SAMP_ALWAYS;
            sample_window_open <= next_state == PW_SAMP ||
                window_timer[SAMP_LSB +: 8] == SAMP_ALWAYS;
        end
    end

    // RULE15 polarity select
    assign power_control_out = ctrl[CTRL_POL] ? pwc_active : !pwc_active;
endmodule : rpw_alarm_window

// ==== hdl/rpw_pkg.sv ====
/*
 * Package for the alarm value registers and power-control window timer:
 * register offsets, field positions, reset values and bus carriers.
 * Assumes a 32-bit AXI4-Lite register bus and one clock.
 */
// What this block does
// RULE1: weekday digit, bits 10:8, values 0-6
// RULE2: hour tens digit, bits 5:4, 0-2
// RULE3: hour ones digit, bits 3:0, 0-9
// RULE4: value writes only while write enable set
// RULE5: minute tens 14:12, minute ones 11:8
// RULE6: second tens 6:4, second ones 3:0
// RULE7: unimplemented alarm bits ignore writes, read zero
// RULE8: stability setting N gives N clock periods
// RULE9: zero stability starts sample at alarm
// RULE10: sample all ones keeps window always open
// RULE11: sample setting N gives N periods open
// RULE12: zero sample setting suppresses sample window
// RULE13: sampling starts when stability timer expires
// RULE14: sequencing needs module, enable, output select
// RULE15: polarity bit selects output active level
// RULE16: hardware clears alarm enable on alarm
// RULE17: mask selects which digits must match
// RULE18: counters load at alarm, decrement per period
// RULE19: output asserted from alarm until sample closes
package rpw_pkg;
    localparam logic [7:0] ADDR_ALARM_WDHR = 8'h00;
    localparam logic [7:0] ADDR_ALARM_MINSEC = 8'h04;
    localparam logic [7:0] ADDR_WINDOW = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // wdhr fields
    localparam int ALARM_WEEKDAY_DIGIT_LSB = 8;
    localparam int ALARM_HOUR_TENS_LSB = 4;
    localparam int ALARM_HOUR_ONES_LSB = 0;
    localparam logic [15:0] WDHR_MASK = 16'h073f;
    // minsec fields
    localparam int ALARM_MINUTE_TENS_LSB = 12;
    localparam int ALARM_MINUTE_ONES_LSB = 8;
    localparam int ALARM_SECOND_TENS_LSB = 4;
    localparam int ALARM_SECOND_ONES_LSB = 0;
    localparam logic [15:0] MINSEC_MASK = 16'h7f7f;
    // window fields
    localparam int STAB_LSB = 8;
    localparam int SAMP_LSB = 0;
    localparam logic [7:0] SAMP_ALWAYS = 8'hff;
    // control bits
    localparam int CTRL_WREN = 0;
    localparam int CTRL_MODULE_EN = 1;
    localparam int CTRL_OUT_SEL = 2;
    localparam int CTRL_PWC_EN = 3;
    localparam int CTRL_POL = 4;
    localparam int CTRL_ALARM_EN = 5;
    localparam int CTRL_MASK_LSB = 8;
    localparam logic [15:0] CTRL_MASK = 16'h0f3f;
    localparam logic [15:0] RESET_VAL = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [3:0] alarm_weekday_digit;
        logic [3:0] hr_tens;
        logic [3:0] hr_ones;
        logic [3:0] min_tens;
        logic [3:0] min_ones;
        logic [3:0] sec_tens;
        logic [3:0] sec_ones;
    } rpw_time_t;

    typedef enum logic [2:0] {
        PW_IDLE = 3'b001,
        PW_STAB = 3'b010,
        PW_SAMP = 3'b100
    } rpw_state_t;
endpackage : rpw_pkg

// ==== verif/rpw_alarm_window_properties.sv ====
/* checker: bus answers, reserved read bits and alarm pulse timing.
   bound to the alarm window block from the bench top. */
`timescale 1ns/1ps
module rpw_alarm_window_properties
    import rpw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pwc_tick,
    input wire logic alarm_event
);
    logic [7:0] rd_addr;

    // remember which register the pending read answers for
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
        begin
            rd_addr <= s_axi_araddr;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read not answered in one cycle");
    a_write_answer: assert property
        (aw_w_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_bresp_done: assert property
        (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_rresp_done: assert property
        (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_wdhr_reserved: assert property
        (s_axi_rvalid && rd_addr == ADDR_ALARM_WDHR
        |-> (s_axi_rdata & ~{16'h0, WDHR_MASK}) == 32'h0)
        else $error("weekday hours reserved bit set");
    a_minsec_reserved: assert property
        (s_axi_rvalid && rd_addr == ADDR_ALARM_MINSEC
        |-> (s_axi_rdata & ~{16'h0, MINSEC_MASK}) == 32'h0)
        else $error("minutes seconds reserved bit set");
    a_event_once: assert property
        (alarm_event |=> !alarm_event [*3])
        else $error("alarm fired again without re-enable");
    a_event_on_tick: assert property
        (alarm_event |-> $past(pwc_tick))
        else $error("alarm not aligned to compare tick");
endmodule : rpw_alarm_window_properties

// ==== verif/rpw_ext_device.sv ====
/* model of the external part that the power-control pin switches.
   assumes the bench tells it which pin level means power on. */
`timescale 1ns/1ps
module rpw_ext_device
(
    input wire logic pin,
    input wire logic active_high,
    output logic powered,
    output int power_ups
);
    assign powered = (pin === active_high);
    initial power_ups = 0;
    always @(posedge powered)
    begin
        power_ups++;
    end
endmodule : rpw_ext_device

// ==== verif/rpw_alarm_window_tb_top.sv ====
/* bench top: register bus master, compare tick and alarm scenarios.
   assumes the block answers within a few cycles; a watchdog ends a hang. */
`timescale 1ns/1ps
module rpw_alarm_window_tb_top
    import rpw_pkg::*;
;
    logic aclk, aresetn, pwc_tick, pol, powered;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rready, s_axi_rvalid, alarm_event;
    logic power_control_out, sample_window_open;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, tdiv;
    rpw_time_t time_now;
    int power_ups, miscompares, comparisons, cyc;

    rpw_alarm_window dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .time_now(time_now),
        .pwc_tick(pwc_tick), .alarm_event(alarm_event),
        .power_control_out(power_control_out),
        .sample_window_open(sample_window_open));
    rpw_ext_device ext (.pin(power_control_out), .active_high(pol),
        .powered(powered), .power_ups(power_ups));

    initial
    begin
        aclk = 0;
        forever #25 aclk = ~aclk;
    end

    // compare tick every fourth cycle; watchdog ends a hang
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tdiv <= 2'h0;
            pwc_tick <= 1'b0;
        end
        else
        begin
            tdiv <= tdiv + 2'h1;
            pwc_tick <= (tdiv == 2'h3);
        end
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit pa;
        bit pw;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        pa = 1;
        pw = 1;
        while (pa || pw)
        begin
            @(posedge aclk);
            if (pa && s_axi_awready)
            begin
                s_axi_awvalid <= 1'b0;
                pa = 0;
            end
            if (pw && s_axi_wready)
            begin
                s_axi_wvalid <= 1'b0;
                pw = 0;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (!s_axi_rvalid) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk("register", e, d);
    endtask : rc

    task automatic regs_test();
        logic [31:0] d;
        logic [1:0] r;
        rc(ADDR_ALARM_WDHR, 32'h0);
        wr(ADDR_ALARM_WDHR, 32'hffff);
        wr(ADDR_WINDOW, 32'h1234);
        rc(ADDR_ALARM_WDHR, 32'h0);
        rc(ADDR_WINDOW, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_ALARM_WDHR, 32'hffff);
        rc(ADDR_ALARM_WDHR, 32'h073f);
        wr(ADDR_ALARM_WDHR, 32'h0629);
        rc(ADDR_ALARM_WDHR, 32'h0629);
        wr(ADDR_ALARM_MINSEC, 32'hffff);
        rc(ADDR_ALARM_MINSEC, 32'h7f7f);
        wr(ADDR_ALARM_MINSEC, 32'h5959);
        rc(ADDR_ALARM_MINSEC, 32'h5959);
        rd(8'h20, d, r);
        chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    endtask : regs_test

    // seconds-ones mask keeps the alarm quiet until time_now is moved
    task automatic run(input logic [7:0] st, input logic [7:0] sa,
        input logic p);
        int n;
        int w;
        int ups;
        logic [31:0] d;
        logic [1:0] r;
        wr(ADDR_WINDOW, {16'h0, st, sa});
        wr(ADDR_CTRL, {20'h0, 4'h2, 2'h0, 1'b1, p, 4'hf});
        // polarity swap glitches the model; count power-ups after it
        pol <= p;
        @(posedge aclk);
        ups = power_ups;
        time_now.sec_ones <= 4'h9;
        n = 0;
        while (!alarm_event && n < 12)
        begin
            @(posedge aclk);
            n++;
        end
        chk("alarm", 32'h1, {31'h0, alarm_event});
        n = 0;
        while (!sample_window_open && n < 4 * st + 8)
        begin
            @(posedge aclk);
            n++;
        end
        if (sa != 0)
            chk("powered", 32'h1, {31'h0, powered});
        w = 0;
        while (sample_window_open && w < 1200)
        begin
            @(posedge aclk);
            w++;
        end
        repeat (2) @(posedge aclk);
        if (sa == 0)
            chk("no window", 32'h0, w);
        else
        begin
            chk("stab", 32'h1, n + 2 >= 4 * st && n <= 4 * st + 1);
            chk("samp", 32'h1, w + 1 >= 4 * sa && w <= 4 * sa + 1);
        end
        chk("off", 32'h0, {31'h0, powered});
        chk("ups", ups + 1, power_ups);
        rd(ADDR_CTRL, d, r);
        chk("alarm en", 32'h0, {31'h0, d[5]});
        time_now <= '0;
    endtask : run

    // power-control enable low: the alarm fires but nothing powers up
    task automatic off_test();
        int ups;
        int n;
        wr(ADDR_WINDOW, 32'h0102);
        wr(ADDR_CTRL, {20'h0, 4'h2, 2'h0, 1'b1, 1'b0, 4'h7});
        pol <= 1'b0;
        @(posedge aclk);
        ups = power_ups;
        time_now.sec_ones <= 4'h9;
        n = 0;
        while (!alarm_event && n < 12)
        begin
            @(posedge aclk);
            n++;
        end
        chk("alarm", 32'h1, {31'h0, alarm_event});
        repeat (8) @(posedge aclk);
        chk("ups", ups, power_ups);
        chk("window", 32'h0, {31'h0, sample_window_open});
        time_now <= '0;
    endtask : off_test

    task automatic ff_test();
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_WINDOW, 32'h00ff);
        repeat (2) @(posedge aclk);
        chk("open", 32'h1, {31'h0, sample_window_open});
        wr(ADDR_WINDOW, 32'h0);
        repeat (2) @(posedge aclk);
        chk("closed", 32'h0, {31'h0, sample_window_open});
    endtask : ff_test

    initial
    begin
        aresetn = 0;
        s_axi_awvalid = 0;
        s_axi_wvalid = 0;
        s_axi_bready = 0;
        s_axi_arvalid = 0;
        s_axi_rready = 0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        time_now = '0;
        pol = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        regs_test();
        run(8'h02, 8'h03, 1'b1);
        run(8'h00, 8'h02, 1'b0);
        run(8'h01, 8'h00, 1'b1);
        off_test();
        ff_test();
        end_of_test();
    end
endmodule : rpw_alarm_window_tb_top

bind rpw_alarm_window rpw_alarm_window_properties u_props (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pwc_tick(pwc_tick), .alarm_event(alarm_event));
